/* File: verilog/cpwm_defs.svh */
// register indexes, control fields and reset values of the complementary pwm block
`ifndef CPWM_DEFS_SVH
`define CPWM_DEFS_SVH
`define CPWM_IDX_CTRL        4'h0
`define CPWM_IDX_PEAK_CMP    4'h1
`define CPWM_IDX_P1_CMP      4'h2
`define CPWM_IDX_PEAK_BUF    4'h3
`define CPWM_IDX_P1_BUF      4'h4
`define CPWM_IDX_P2_CMP      4'h5
`define CPWM_IDX_P3_CMP      4'h6
`define CPWM_IDX_P2_BUF      4'h7
`define CPWM_IDX_P3_BUF      4'h8
`define CPWM_IDX_CNT1        4'h9
`define CPWM_IDX_CNT2        4'hA
`define CPWM_IDX_DEAD        4'hB
`define CPWM_IDX_HALF        4'hC
`define CPWM_IDX_HALF_BUF    4'hD
`define CPWM_IDX_SKIP        4'hE
`define CPWM_IDX_STATUS      4'hF
`define CPWM_CTRL_RUN        0
`define CPWM_CTRL_NODEAD     1
`define CPWM_CTRL_TOGGLE_EN  2
`define CPWM_CTRL_POS_LVL    3
`define CPWM_CTRL_NEG_LVL    4
`define CPWM_CTRL_PEAK_IE    5
`define CPWM_CTRL_TROUGH_IE  6
`define CPWM_CTRL_PRESC_LSB  7
`define CPWM_CTRL_W          9
`define CPWM_RST_CTRL        9'h000
`define CPWM_RST_PEAK        16'h0104
`define CPWM_RST_DUTY        16'h0082
`define CPWM_RST_DEAD        16'h0004
`define CPWM_RST_HALF        16'h0100
`define CPWM_RST_SKIP        4'h0
`define CPWM_RST_TOGGLE      1'b1
`endif

/* File: verilog/cpwm_pkg.sv */
// types shared by the complementary pwm block
package cpwm_pkg;
  typedef enum logic {DIR_UP = 1'b0, DIR_DOWN = 1'b1} dir_t;
  typedef struct packed {
    logic carrier_toggle_out;
    logic phase1_pos_out;
    logic phase1_neg_out;
    logic phase2_pos_out;
    logic phase2_neg_out;
    logic phase3_pos_out;
    logic phase3_neg_out;
  } pwm_pins_t;
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [3:0]  addr;
    logic [15:0] wdata;
  } reg_req_t;
endpackage

/* File: verilog/three_phase_complementary_pwm.sv */
// three-phase complementary pwm generator with buffered duty and carrier toggle
`timescale 1ns/1ns
`default_nettype none
`include "cpwm_defs.svh"
module three_phase_complementary_pwm (
  input  wire logic                core_clk_i,
  input  wire logic                rst_n_i,
  input  wire cpwm_pkg::reg_req_t  req_i,
  output logic [15:0]              rdata_o,
  output cpwm_pkg::pwm_pins_t      pwm_o,
  output logic                     peak_irq_o,
  output logic                     trough_irq_o,
  output logic                     adc_trig_o
);
  function automatic logic pin_level(input logic act, input logic act_high);
    pin_level = act ? act_high : ~act_high;
  endfunction

  function automatic logic [5:0] presc_mask(input logic [1:0] sel);
    case (sel)
      2'h0:    presc_mask = 6'h00;
      2'h1:    presc_mask = 6'h03;
      2'h2:    presc_mask = 6'h0F;
      default: presc_mask = 6'h3F;
    endcase
  endfunction

  logic [`CPWM_CTRL_W-1:0] ctrl_r, ctrl_nxt;
  logic [15:0] peak_r, peak_nxt, peak_buf_r, peak_buf_nxt;
  logic [15:0] half_r, half_nxt, half_buf_r, half_buf_nxt, dead_r, dead_nxt;
  logic [15:0] cnt1_r, cnt1_nxt, cnt2_r, cnt2_nxt;
  logic [15:0] cmp_r [3], cmp_nxt [3], buf_r [3], buf_nxt [3];
  logic [15:0] stage_r [3], stage_nxt [3];
  logic [3:0]  skip_r, skip_nxt, skip_cnt_r, skip_cnt_nxt;
  logic [5:0]  div_r, div_nxt;
  logic [15:0] rdata_nxt;
  logic        armed_r, armed_nxt, tog_r, tog_nxt;
  cpwm_pkg::dir_t dir1_r, dir1_nxt, dir2_r, dir2_nxt;
  logic        running, tick, peak_evt, trough_evt, start_evt, arm, xfer;
  logic        wr_run, wr_idle, adc_nxt, adc_r;

  assign running    = ctrl_r[`CPWM_CTRL_RUN];
  assign tick       = running && ((div_r & presc_mask(ctrl_r[`CPWM_CTRL_PRESC_LSB +: 2])) == 6'h00);
  assign peak_evt   = tick && dir1_r == cpwm_pkg::DIR_UP && cnt1_r >= peak_r;
  assign trough_evt = tick && dir1_r == cpwm_pkg::DIR_DOWN && cnt1_r <= dead_r;
  assign start_evt  = req_i.wr && req_i.addr == `CPWM_IDX_CTRL && req_i.wdata[`CPWM_CTRL_RUN] && !running;
  assign wr_run     = req_i.wr && running;
  assign wr_idle    = req_i.wr && !running;
  assign arm        = req_i.wr && req_i.addr == `CPWM_IDX_P3_BUF;
  assign xfer       = armed_r && (peak_evt || trough_evt);

  always_comb begin
    ctrl_nxt     = ctrl_r;
    peak_nxt     = peak_r;
    peak_buf_nxt = peak_buf_r;
    half_nxt     = half_r;
    half_buf_nxt = half_buf_r;
    dead_nxt     = dead_r;
    cnt1_nxt     = cnt1_r;
    cnt2_nxt     = cnt2_r;
    dir1_nxt     = dir1_r;
    dir2_nxt     = dir2_r;
    skip_nxt     = skip_r;
    skip_cnt_nxt = skip_cnt_r;
    tog_nxt      = tog_r;
    armed_nxt    = armed_r;
    adc_nxt      = 1'b0;
    div_nxt      = running ? div_r + 6'h01 : 6'h00;
    for (int i = 0; i < 3; i++) begin
      cmp_nxt[i]   = cmp_r[i];
      buf_nxt[i]   = buf_r[i];
      stage_nxt[i] = stage_r[i];
    end
    if (req_i.wr) begin
      case (req_i.addr)
        `CPWM_IDX_CTRL:     ctrl_nxt = req_i.wdata[`CPWM_CTRL_W-1:0];
        `CPWM_IDX_PEAK_BUF: peak_buf_nxt = req_i.wdata;
        `CPWM_IDX_P1_BUF:   buf_nxt[0] = req_i.wdata;
        `CPWM_IDX_P2_BUF:   buf_nxt[1] = req_i.wdata;
        `CPWM_IDX_P3_BUF:   buf_nxt[2] = req_i.wdata;
        `CPWM_IDX_DEAD:     dead_nxt = req_i.wdata;
        `CPWM_IDX_HALF_BUF: half_buf_nxt = req_i.wdata;
        `CPWM_IDX_SKIP:     skip_nxt = req_i.wdata[3:0];
        default: ;
      endcase
    end
    if (wr_idle) begin
      case (req_i.addr)
        `CPWM_IDX_PEAK_CMP: peak_nxt = req_i.wdata;
        `CPWM_IDX_P1_CMP:   cmp_nxt[0] = req_i.wdata;
        `CPWM_IDX_P2_CMP:   cmp_nxt[1] = req_i.wdata;
        `CPWM_IDX_P3_CMP:   cmp_nxt[2] = req_i.wdata;
        `CPWM_IDX_CNT1:     cnt1_nxt = req_i.wdata;
        `CPWM_IDX_CNT2:     cnt2_nxt = req_i.wdata;
        `CPWM_IDX_HALF:     half_nxt = req_i.wdata;
        default: ;
      endcase
    end
    if (tick) begin
      if (peak_evt) begin
        dir1_nxt = cpwm_pkg::DIR_DOWN;
        cnt1_nxt = cnt1_r - 16'h0001;
      end else if (trough_evt) begin
        dir1_nxt = cpwm_pkg::DIR_UP;
        cnt1_nxt = cnt1_r + 16'h0001;
      end else begin
        cnt1_nxt = (dir1_r == cpwm_pkg::DIR_UP) ? cnt1_r + 16'h0001 : cnt1_r - 16'h0001;
      end
      if (dir2_r == cpwm_pkg::DIR_UP && cnt2_r >= half_r) begin
        dir2_nxt = cpwm_pkg::DIR_DOWN;
        cnt2_nxt = cnt2_r - 16'h0001;
      end else if (dir2_r == cpwm_pkg::DIR_DOWN && cnt2_r == 16'h0000) begin
        dir2_nxt = cpwm_pkg::DIR_UP;
        cnt2_nxt = cnt2_r + 16'h0001;
      end else begin
        cnt2_nxt = (dir2_r == cpwm_pkg::DIR_UP) ? cnt2_r + 16'h0001 : cnt2_r - 16'h0001;
      end
    end
    if (peak_evt || trough_evt) begin
      half_nxt = half_buf_r;
      peak_nxt = peak_buf_r;
      if (ctrl_r[`CPWM_CTRL_TOGGLE_EN]) begin
        tog_nxt = ~tog_r;
      end
    end
    if (trough_evt) begin
      if (skip_cnt_r >= skip_r) begin
        skip_cnt_nxt = 4'h0;
        adc_nxt      = 1'b1;
      end else begin
        skip_cnt_nxt = skip_cnt_r + 4'h1;
      end
    end
    if (xfer) begin
      for (int i = 0; i < 3; i++) begin
        cmp_nxt[i] = stage_r[i];
      end
    end
    if (arm) begin
      stage_nxt[0] = buf_r[0];
      stage_nxt[1] = buf_r[1];
      stage_nxt[2] = req_i.wdata;
    end
    armed_nxt = arm ? 1'b1 : (xfer ? 1'b0 : armed_r);
    // counters start at dead and zero
    if (start_evt) begin
      cnt1_nxt     = dead_r;
      cnt2_nxt     = 16'h0000;
      dir1_nxt     = cpwm_pkg::DIR_UP;
      dir2_nxt     = cpwm_pkg::DIR_UP;
      skip_cnt_nxt = 4'h0;
    end
    rdata_nxt = rdata_o;
    if (req_i.rd) begin
      case (req_i.addr)
        `CPWM_IDX_CTRL:     rdata_nxt = {{(16 - `CPWM_CTRL_W){1'b0}}, ctrl_r};
        `CPWM_IDX_PEAK_CMP: rdata_nxt = peak_r;
        `CPWM_IDX_P1_CMP:   rdata_nxt = cmp_r[0];
        `CPWM_IDX_PEAK_BUF: rdata_nxt = peak_buf_r;
        `CPWM_IDX_P1_BUF:   rdata_nxt = buf_r[0];
        `CPWM_IDX_P2_CMP:   rdata_nxt = cmp_r[1];
        `CPWM_IDX_P3_CMP:   rdata_nxt = cmp_r[2];
        `CPWM_IDX_P2_BUF:   rdata_nxt = buf_r[1];
        `CPWM_IDX_P3_BUF:   rdata_nxt = buf_r[2];
        `CPWM_IDX_CNT1:     rdata_nxt = cnt1_r;
        `CPWM_IDX_CNT2:     rdata_nxt = cnt2_r;
        `CPWM_IDX_DEAD:     rdata_nxt = dead_r;
        `CPWM_IDX_HALF:     rdata_nxt = half_r;
        `CPWM_IDX_HALF_BUF: rdata_nxt = half_buf_r;
        `CPWM_IDX_SKIP:     rdata_nxt = {12'h000, skip_r};
        default:            rdata_nxt = {11'h000, tog_r, dir2_r, dir1_r, armed_r, running};
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_r     <= `CPWM_RST_CTRL;
      peak_r     <= `CPWM_RST_PEAK;
      peak_buf_r <= `CPWM_RST_PEAK;
      half_r     <= `CPWM_RST_HALF;
      half_buf_r <= `CPWM_RST_HALF;
      dead_r     <= `CPWM_RST_DEAD;
      cnt1_r     <= `CPWM_RST_DEAD;
      cnt2_r     <= 16'h0000;
      dir1_r     <= cpwm_pkg::DIR_UP;
      dir2_r     <= cpwm_pkg::DIR_UP;
      skip_r     <= `CPWM_RST_SKIP;
      skip_cnt_r <= 4'h0;
      tog_r      <= `CPWM_RST_TOGGLE;
      armed_r    <= 1'b0;
      adc_r      <= 1'b0;
      div_r      <= 6'h00;
      rdata_o    <= 16'h0000;
      for (int i = 0; i < 3; i++) begin
        cmp_r[i]   <= `CPWM_RST_DUTY;
        buf_r[i]   <= `CPWM_RST_DUTY;
        stage_r[i] <= `CPWM_RST_DUTY;
      end
    end else begin
      ctrl_r     <= ctrl_nxt;
      peak_r     <= peak_nxt;
      peak_buf_r <= peak_buf_nxt;
      half_r     <= half_nxt;
      half_buf_r <= half_buf_nxt;
      dead_r     <= dead_nxt;
      cnt1_r     <= cnt1_nxt;
      cnt2_r     <= cnt2_nxt;
      dir1_r     <= dir1_nxt;
      dir2_r     <= dir2_nxt;
      skip_r     <= skip_nxt;
      skip_cnt_r <= skip_cnt_nxt;
      tog_r      <= tog_nxt;
      armed_r    <= armed_nxt;
      adc_r      <= adc_nxt;
      div_r      <= div_nxt;
      rdata_o    <= rdata_nxt;
      for (int i = 0; i < 3; i++) begin
        cmp_r[i]   <= cmp_nxt[i];
        buf_r[i]   <= buf_nxt[i];
        stage_r[i] <= stage_nxt[i];
      end
    end
  end

  // per-phase dead-time insertion
  logic [15:0] hold_r [3], hold_nxt [3];
  logic [2:0]  raw_r, raw_nxt, pos_act, neg_act;
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      raw_nxt[i]  = running && (cnt2_r >= cmp_r[i]) && (cmp_r[i] < peak_r);
      hold_nxt[i] = (raw_nxt[i] != raw_r[i]) ? 16'h0000 :
                    ((hold_r[i] == 16'hFFFF) ? hold_r[i] : hold_r[i] + 16'h0001);
      // turn-on waits out the dead time
      pos_act[i]  = raw_r[i] && (ctrl_r[`CPWM_CTRL_NODEAD] || hold_r[i] >= dead_r);
      neg_act[i]  = running && !raw_r[i] && (ctrl_r[`CPWM_CTRL_NODEAD] || hold_r[i] >= dead_r);
    end
  end
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      raw_r <= 3'h0;
      for (int i = 0; i < 3; i++) begin
        hold_r[i] <= 16'h0000;
      end
    end else begin
      raw_r <= raw_nxt;
      for (int i = 0; i < 3; i++) begin
        hold_r[i] <= hold_nxt[i];
      end
    end
  end

  assign pwm_o.carrier_toggle_out = tog_r;
  assign pwm_o.phase1_pos_out     = pin_level(pos_act[0], ctrl_r[`CPWM_CTRL_POS_LVL]);
  assign pwm_o.phase1_neg_out     = pin_level(neg_act[0], ctrl_r[`CPWM_CTRL_NEG_LVL]);
  assign pwm_o.phase2_pos_out     = pin_level(pos_act[1], ctrl_r[`CPWM_CTRL_POS_LVL]);
  assign pwm_o.phase2_neg_out     = pin_level(neg_act[1], ctrl_r[`CPWM_CTRL_NEG_LVL]);
  assign pwm_o.phase3_pos_out     = pin_level(pos_act[2], ctrl_r[`CPWM_CTRL_POS_LVL]);
  assign pwm_o.phase3_neg_out     = pin_level(neg_act[2], ctrl_r[`CPWM_CTRL_NEG_LVL]);
  assign peak_irq_o   = peak_evt && ctrl_r[`CPWM_CTRL_PEAK_IE];
  assign trough_irq_o = trough_evt && ctrl_r[`CPWM_CTRL_TROUGH_IE];
  assign adc_trig_o   = adc_r;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence turn_s;
    peak_evt || trough_evt;
  endsequence
  sequence flip_s;
    tog_r != $past(tog_r);
  endsequence

  cnt1_to_down_a: assert property (peak_evt && !start_evt |=> dir1_r == cpwm_pkg::DIR_DOWN)
    else $error("first counter did not turn down at peak");
  cnt1_to_up_a: assert property (trough_evt && !start_evt |=> dir1_r == cpwm_pkg::DIR_UP)
    else $error("first counter did not turn up at dead time");
  cnt2_turn_a: assert property (tick && dir2_r == cpwm_pkg::DIR_DOWN && cnt2_r == 16'h0000
    |=> cnt2_r == 16'h0001)
    else $error("second counter did not rise from zero");
  start_load_a: assert property (start_evt |=> cnt1_r == $past(dead_r) && cnt2_r == 16'h0000)
    else $error("counters not loaded at start");
  neg_gap_a: assert property ($rose(neg_act[0]) && $past(running) && !ctrl_r[`CPWM_CTRL_NODEAD]
    |-> $past(hold_r[0]) + 16'h0001 >= dead_r)
    else $error("antiphase turn-on came before dead time elapsed");
  dead_gap_a: assert property ($rose(pos_act[0]) && !ctrl_r[`CPWM_CTRL_NODEAD]
    |-> $past(hold_r[0]) + 16'h0001 >= dead_r)
    else $error("turn-on came before dead time elapsed");
  stage_xfer_a: assert property (xfer |=> cmp_r[0] == $past(stage_r[0]) && cmp_r[2] == $past(stage_r[2]))
    else $error("hidden stage not copied to compare");
  cmp_guard_a: assert property (wr_run && !xfer |=> cmp_r[0] == $past(cmp_r[0]))
    else $error("compare changed while running without transfer");
  half_load_a: assert property (turn_s |=> half_r == $past(half_buf_r))
    else $error("half-cycle not reloaded at turning point");
  toggle_flip_a: assert property (turn_s ##0 ctrl_r[`CPWM_CTRL_TOGGLE_EN] |=> flip_s)
    else $error("carrier toggle did not flip");
  duty_zero_a: assert property (running && cmp_r[0] == 16'h0000 && !start_evt |=> raw_r[0])
    else $error("zero duty did not hold positive phase on");
endmodule // three_phase_complementary_pwm
`default_nettype wire

/* File: bench/gate_driver_model.sv */
// gate driver model that watches the six phase legs
`timescale 1ns/1ns
`default_nettype none
module gate_driver_model (
  input  wire logic                core_clk_i,
  input  wire cpwm_pkg::pwm_pins_t pins_i,
  input  wire logic                pos_lvl_i,
  input  wire logic                neg_lvl_i,
  output var  int                  overlaps_o,
  output var  int                  edges_o
);
  cpwm_pkg::pwm_pins_t last_r;
  int                  ovl = 0;
  int                  edg = 0;
  assign overlaps_o = ovl;
  assign edges_o    = edg;
  // legs judged mid-cycle, once pins and levels have settled
  always @(negedge core_clk_i) begin
    if ((pins_i.phase1_pos_out === pos_lvl_i && pins_i.phase1_neg_out === neg_lvl_i) ||
        (pins_i.phase2_pos_out === pos_lvl_i && pins_i.phase2_neg_out === neg_lvl_i) ||
        (pins_i.phase3_pos_out === pos_lvl_i && pins_i.phase3_neg_out === neg_lvl_i)) begin
      ovl <= ovl + 1;
    end
    // phase-two positive leg really switches, unknown start not counted
    if ((pins_i.phase2_pos_out ^ last_r.phase2_pos_out) === 1'b1) begin
      edg <= edg + 1;
    end
    last_r <= pins_i;
  end
endmodule // gate_driver_model
`default_nettype wire

/* File: bench/tb_top.sv */
// self-checking bench of the complementary pwm generator
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic                core_clk_i = 1'b0;
  logic                rst_n_i = 1'b0;
  cpwm_pkg::reg_req_t  req = '0;
  logic [15:0]         rdata;
  cpwm_pkg::pwm_pins_t pins;
  logic                peak_irq;
  logic                trough_irq;
  logic                adc_trig;
  int                  overlaps;
  int                  edges;
  int                  mismatches = 0;
  int                  n_compared = 0;
  int                  e [16] = '{0, 16'h0104, 16'h0082, 16'h0104, 16'h0082, 16'h0082, 16'h0082, 16'h0082,
                                  16'h0082, 16'h0004, 0, 16'h0004, 16'h0100, 16'h0100, 0, 16'h0010};
  int                  s1, s2, s3, pend, n;
  logic                tog_exp = 1'b1;
  logic [31:0]         seed = 32'h1E;
  logic [31:0]         r;
  logic [3:0]          ca [11] = '{4'hB, 4'hC, 4'hD, 4'h1, 4'h3, 4'h2, 4'h4, 4'h5, 4'h7, 4'h6, 4'hE};
  logic [15:0]         cd [11] = '{16'h2, 16'h8, 16'h8, 16'hA, 16'hA, 16'h0, 16'h0, 16'h4, 16'h4, 16'hA, 16'h1};
  logic [3:0]          ua [5] = '{4'h1, 4'h2, 4'h5, 4'h6, 4'hC};

  always #4 core_clk_i = ~core_clk_i;

  three_phase_complementary_pwm DUT (
    .core_clk_i   (core_clk_i),
    .rst_n_i      (rst_n_i),
    .req_i        (req),
    .rdata_o      (rdata),
    .pwm_o        (pins),
    .peak_irq_o   (peak_irq),
    .trough_irq_o (trough_irq),
    .adc_trig_o   (adc_trig)
  );

  gate_driver_model drv (
    .core_clk_i (core_clk_i),
    .pins_i     (pins),
    .pos_lvl_i  (e[0][3]),
    .neg_lvl_i  (e[0][4]),
    .overlaps_o (overlaps),
    .edges_o    (edges)
  );

  // reference model: buffered copies at each peak or trough, taken mid-cycle so register writes cannot race it
  always @(negedge core_clk_i) begin
    if (e[0][0] && (peak_irq === 1'b1 || trough_irq === 1'b1)) begin
      e[1] = e[3];
      e[12] = e[13];
      if (e[0][2]) tog_exp = ~tog_exp;
      if (pend != 0) begin
        e[2] = s1;
        e[5] = s2;
        e[6] = s3;
        pend = 0;
      end
    end
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic ev(input int sel);
    return sel == 0 ? peak_irq : (sel == 1 ? trough_irq : adc_trig);
  endfunction

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick();
    @(posedge core_clk_i);
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk_i);
    req.wr <= 1'b1;
    req.addr <= a;
    req.wdata <= d;
    @(posedge core_clk_i);
    req.wr <= 1'b0;
    if (!(e[0][0] && a inside {4'h1, 4'h2, 4'h5, 4'h6, 4'h9, 4'hA, 4'hC}) && a != 4'hF) e[a] = d;
    if (a == 4'h8) begin
      s1 = e[4];
      s2 = e[7];
      s3 = d;
      pend = 1;
    end
  endtask

  task automatic rd_chk(input logic [3:0] a);
    @(posedge core_clk_i);
    req.rd <= 1'b1;
    req.addr <= a;
    @(posedge core_clk_i);
    req.rd <= 1'b0;
    tick();
    chk(rdata, e[a][15:0]);
  endtask

  // cycles from one event of a kind to the next
  task automatic gap(input int sel, output int cnt);
    cnt = 0;
    tick();
    while (ev(sel) !== 1'b1 && cnt < 600) begin
      tick();
      cnt++;
    end
    cnt = 0;
    do begin
      tick();
      cnt++;
    end while (ev(sel) !== 1'b1 && cnt < 600);
  endtask

  // cycles of a window with both phase-one legs inactive
  task automatic both_off(output int cnt);
    cnt = 0;
    repeat (48) begin
      tick();
      if (pins.phase1_pos_out === ~e[0][3] && pins.phase1_neg_out === ~e[0][4]) cnt++;
    end
  endtask

  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // span well beyond the expected run
  initial begin
    #100000;
    mismatches++;
    end_sim();
  end

  initial begin
    repeat (8) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    for (int i = 0; i < 16; i++) rd_chk(4'(i));
    r = xs();
    wr(4'hB, r[15:0]);
    rd_chk(4'hB);
    $display("register test done");
    foreach (ca[i]) wr(ca[i], cd[i]);
    wr(4'h0, 16'h0065);
    repeat (40) tick();
    repeat (40) begin
      tick();
      chk({12'h000, pins.phase1_pos_out, pins.phase1_neg_out, pins.phase3_pos_out, pins.phase3_neg_out},
          16'h0006);
    end
    gap(0, n);
    chk(n[15:0], 16'h0010);
    gap(1, n);
    chk(n[15:0], 16'h0010);
    gap(2, n);
    chk(n[15:0], 16'h0020);
    chk({15'h0000, pins.carrier_toggle_out}, {15'h0000, tog_exp});
    chk(overlaps[15:0], 16'h0000);
    chk({15'h0000, edges > 0}, 16'h0001);
    $display("carrier test done");
    wr(4'h2, 16'h0033);
    rd_chk(4'h2);
    wr(4'h4, 16'h0003);
    gap(0, n);
    rd_chk(4'h2);
    r = xs();
    wr(4'h7, 16'(r % 6 + 1));
    wr(4'h3, 16'h0008);
    wr(4'hD, 16'h0006);
    gap(0, n);
    wr(4'h8, 16'h000A);
    rd_chk(4'h2);
    gap(1, n);
    foreach (ua[i]) rd_chk(ua[i]);
    gap(0, n);
    chk(n[15:0], 16'h000C);
    both_off(n);
    chk(n[15:0], 16'(8 * e[11]));
    chk(overlaps[15:0], 16'h0000);
    $display("buffer test done");
    wr(4'h0, 16'h0000);
    repeat (4) tick();
    chk({10'h000, pins[5:0]}, 16'h003F);
    $display("stop test done");
    wr(4'h0, 16'h007B);
    repeat (8) tick();
    both_off(n);
    chk(n[15:0], 16'h0000);
    chk({14'h0000, pins.phase3_pos_out, pins.phase3_neg_out}, 16'h0001);
    chk({15'h0000, pins.carrier_toggle_out}, {15'h0000, tog_exp});
    chk(overlaps[15:0], 16'h0000);
    $display("no dead time test done");
    end_sim();
  end
endmodule // tb_top
`default_nettype wire
